// ==== tb_trace_status_word_encoder.sv ====
/* Bench for the trace encoder: code table, field placement, overflow and drain.
   Assumes design, FIFO, analyzer model and checker are compiled before it. */
`timescale 1ns/1ps
`include "trace_defs.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %h got %h", n, e, g); end end

module tb_trace_status_word_encoder
    import trace_pkg::*;
;
    typedef struct packed {logic mon; logic dma; logic [2:0] fc; logic [2:0] exp_fc;} row_t;
    row_t rows [11] = '{'{1'b0, 1'b0, 3'h1, 3'h1}, '{1'b0, 1'b0, 3'h2, 3'h2},
        '{1'b0, 1'b0, 3'h5, 3'h5}, '{1'b0, 1'b0, 3'h6, 3'h6}, '{1'b0, 1'b0, 3'h7, 3'h7},
        '{1'b0, 1'b1, 3'h5, 3'h3}, '{1'b1, 1'b0, 3'h6, 3'h0}, '{1'b1, 1'b0, 3'h5, 3'h4},
        '{1'b1, 1'b0, 3'h1, 3'h4}, '{1'b1, 1'b1, 3'h6, 3'h3}, '{1'b1, 1'b0, 3'h7, 3'h7}};
    logic clk_i, rst_i, addr_strobe_n_i, upper_byte_strobe_i, read_i, byte_access_i;
    logic peripheral_cycle_flag_i, guarded_access_n_i, rom_access_n_i, monitor_active_i;
    logic dma_tag_i, capture_ready_o, trace_valid_o, trace_ready_i, qual_match_o, stall;
    logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [23:1] addr_i;
    logic [15:0] data_i;
    logic [2:0] func_code_i;
    logic [47:0] trace_rec_o;
    logic [5:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd_q;
    int error_cnt, comparisons, i;

    trace_status_word_encoder u_dut (.*);
    trace_analyzer_model u_ana (.clk_i(clk_i), .stall_i(stall), .valid_i(trace_valid_o),
        .rec_i(trace_rec_o), .ready_o(trace_ready_i));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic test_done();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
        for (k = 0; k < 20; k++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        if (k == 20) begin
            error_cnt++;
            test_done();
        end
        rd_q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : wb

    // one strobe low cycle then one high cycle, the shortest legal bus cycle
    task automatic bus(input int n);
        @(posedge clk_i);
        addr_strobe_n_i <= 1'b0;
        addr_i <= 23'h5A5A0 + 23'(n);
        data_i <= 16'hC3A0 + 16'(n);
        {upper_byte_strobe_i, read_i, byte_access_i} <= 3'(n);
        {peripheral_cycle_flag_i, guarded_access_n_i, rom_access_n_i} <= 3'(n + 3);
        @(posedge clk_i);
        addr_strobe_n_i <= 1'b1;
    endtask : bus

    function automatic logic [47:0] exp_rec(input int n, input logic [2:0] f);
        logic [2:0] a;
        logic [2:0] b;
        a = 3'(n);
        b = 3'(n + 3);
        return {16'hC3A0 + 16'(n), b[1], b[0], f, b[2], a[1], a[0], 23'h5A5A0 + 23'(n), a[2]};
    endfunction : exp_rec

    task automatic wait_got(input int n);
        int k;
        for (k = 0; k < 200 && u_ana.got.size() < n; k++) @(posedge clk_i);
        if (u_ana.got.size() < n) begin
            error_cnt++;
            test_done();
        end
    endtask : wait_got

    initial begin
        {rst_i, addr_strobe_n_i, guarded_access_n_i, rom_access_n_i} = 4'hF;
        {upper_byte_strobe_i, read_i, byte_access_i, peripheral_cycle_flag_i} = 4'h0;
        {monitor_active_i, dma_tag_i, stall, wb_cyc_i, wb_stb_i, wb_we_i} = 6'h00;
        {addr_i, data_i, func_code_i, wb_adr_i, wb_dat_i} = '0;
        wb_sel_i = 4'hF;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        `CHK("valid", 1'b0, trace_valid_o)
        `CHK("room", 1'b1, capture_ready_o)
        bus(0);
        wb(1'b1, `OFS_CTRL, 32'h1);
        wb(1'b0, `OFS_CTRL, 32'h0);
        `CHK("ctrl", 32'h0000_0001, rd_q)
        wb(1'b0, 6'h3C, 32'h0);
        `CHK("unmapped", 32'h0000_0000, rd_q)
        `CHK("no capture when disabled", 0, u_ana.got.size())
        for (i = 0; i < 11; i++) begin
            {monitor_active_i, dma_tag_i, func_code_i} <= {rows[i].mon, rows[i].dma, rows[i].fc};
            bus(i);
            wait_got(i + 1);
            `CHK("record", exp_rec(i, rows[i].exp_fc), u_ana.got[i])
        end
        // analyzer stalls: eight records fit, the ninth is dropped
        stall <= 1'b1;
        for (i = 0; i < 9; i++) bus(i);
        repeat (3) @(posedge clk_i);
        `CHK("full", 1'b0, capture_ready_o)
        wb(1'b0, `OFS_STATUS, 32'h0);
        `CHK("status", 32'h0000_0801, rd_q)
        wb(1'b1, `OFS_STATUS, 32'h1);
        wb(1'b0, `OFS_STATUS, 32'h0);
        `CHK("status cleared", 32'h0000_0800, rd_q)
        stall <= 1'b0;
        wait_got(19);
        repeat (5) @(posedge clk_i);
        `CHK("count", 19, u_ana.got.size())
        for (i = 0; i < 8; i++) `CHK("drained", exp_rec(i, 3'h7), u_ana.got[11 + i])
        `CHK("empty", 1'b0, trace_valid_o)
        wb(1'b0, `OFS_MATCH_CNT, 32'h0);
        `CHK("match count", 32'h0000_0013, rd_q)
        // the qualifier is copied at load; a later equate write must not reach it
        wb(1'b1, `OFS_EQU_VAL, 32'h38);
        wb(1'b1, `OFS_EQU_MASK, 32'h38);
        wb(1'b1, `OFS_CTRL, 32'h3);
        wb(1'b1, `OFS_EQU_VAL, 32'h00);
        wb(1'b0, `OFS_QUAL, 32'h0);
        `CHK("qualifier", 32'h0000_3838, rd_q)
        wb(1'b1, `OFS_MATCH_CNT, 32'h0);
        bus(20);
        repeat (3) @(posedge clk_i);
        `CHK("match pulse", 1'b1, qual_match_o)
        {monitor_active_i, func_code_i} <= {1'b0, 3'h1};
        bus(21);
        repeat (3) @(posedge clk_i);
        `CHK("no match pulse", 1'b0, qual_match_o)
        wait_got(21);
        wb(1'b0, `OFS_MATCH_CNT, 32'h0);
        `CHK("match count after load", 32'h0000_0001, rd_q)
        `CHK("monitor record", exp_rec(20, 3'h7), u_ana.got[19])
        `CHK("user record", exp_rec(21, 3'h1), u_ana.got[20])
        // reset in mid-run: enable and qualifier fall back, nothing is captured
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        `CHK("reset valid", 1'b0, trace_valid_o)
        `CHK("reset room", 1'b1, capture_ready_o)
        `CHK("reset ack", 1'b0, wb_ack_o)
        `CHK("reset match", 1'b0, qual_match_o)
        wb(1'b0, `OFS_CTRL, 32'h0);
        `CHK("reset enable", 32'h0000_0000, rd_q)
        wb(1'b0, `OFS_QUAL, 32'h0);
        `CHK("reset qualifier", 32'h0000_0000, rd_q)
        bus(22);
        repeat (4) @(posedge clk_i);
        `CHK("no capture after reset", 21, u_ana.got.size())
        test_done();
    end
endmodule : tb_trace_status_word_encoder

// ==== trace_analyzer_model.sv ====
/* Analyzer stand-in: pops trace records and keeps them in arrival order.
   Assumes valid/ready pop on a rising edge; stall_i holds off popping. */
`timescale 1ns/1ps

module trace_analyzer_model (
    input wire logic clk_i,
    input wire logic stall_i,
    input wire logic valid_i,
    input wire logic [47:0] rec_i,
    output logic ready_o
);
    logic [47:0] got [$];

    initial ready_o = 1'b0;

    // ready follows stall one edge late, so the encoder also sees a slow reader
    always @(posedge clk_i) begin
        if (valid_i && ready_o) begin
            got.push_back(rec_i);
        end
        ready_o <= !stall_i;
    end
endmodule : trace_analyzer_model

// ==== trace_defs.svh ====
/*
 * Constants of the trace status word encoder: record field positions, function code
 * patterns, register offsets and reset values.
 * Assumes it is included by bare name wherever a constant is needed.
 */
// Function
// - foreground cycles pass function codes unchanged
// - dma tag cycle drives pattern 011
// - monitor program 000, monitor data 100
// - other codes 001,010,101,110,111 as processor
// - bit24 byte, bit25 read, bit26 peripheral
// - data lines on record bits 32-47
// - record bits 0-23 form address field
// - record bits 24-31 form status field
// - qualifier keeps pattern latched at entry
// - bit0 upper strobe, bits 1-23 address
// - bit31 guarded low, bit30 rom low
`ifndef TRACE_DEFS_SVH
`define TRACE_DEFS_SVH

`define REC_W 48
`define FIFO_DEPTH 8
`define POS_STROBE 0
`define POS_ADDR_LO 1
`define POS_ADDR_HI 23
`define POS_BYTE 24
`define POS_READ 25
`define POS_PERIPH 26
`define POS_FC_LO 27
`define POS_FC_HI 29
`define POS_ROM_N 30
`define POS_GUARD_N 31
`define POS_STAT_LO 24
`define POS_STAT_HI 31
`define POS_DATA_LO 32
`define POS_DATA_HI 47

`define FC_MON_PROG 3'h0
`define FC_DMA_TAG 3'h3
`define FC_MON_DATA 3'h4
`define FC_INT_ACK 3'h7

`define OFS_CTRL 6'h00
`define OFS_EQU_VAL 6'h04
`define OFS_EQU_MASK 6'h08
`define OFS_QUAL 6'h0C
`define OFS_STATUS 6'h10
`define OFS_MATCH_CNT 6'h14

`define CTRL_ENABLE_BIT 0
`define CTRL_LOAD_BIT 1
`define STATUS_OVF_BIT 0
`define STATUS_LVL_LO 8
`define STATUS_LVL_HI 11

`define RST_ENABLE 1'b0
`define RST_EQU 8'h00
`define RST_MASK 8'h00
`define RST_COUNT 16'h0000

`endif

// ==== trace_fifo.sv ====
/*
 * Record FIFO: parameterised width and depth, valid/ready on both sides.
 * Assumes a synchronous active-high reset and one clock.
 */
`timescale 1ns/1ps

module trace_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    trace_fifo_if.buffer f
);
    import trace_pkg::*;

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } fifo_state_t;

    fifo_state_t s_q;
    fifo_state_t s_d;
    logic do_push;
    logic do_pop;

    // full and empty come straight from the occupancy count, never guessed
    assign f.push_ready = (s_q.count != (AW+1)'(DEPTH));
    assign f.pop_valid = (s_q.count != '0);
    assign f.pop_data = s_q.mem[s_q.rd_ptr];
    assign f.level = 4'(s_q.count);
    assign do_push = f.push_valid && f.push_ready;
    assign do_pop = f.pop_valid && f.pop_ready;

    always_comb begin
        s_d = s_q;
        if (do_push) begin
            s_d.mem[s_q.wr_ptr] = f.push_data;
            s_d.wr_ptr = (s_q.wr_ptr == AW'(DEPTH - 1)) ? '0 : s_q.wr_ptr + 1'b1;
        end
        if (do_pop) begin
            s_d.rd_ptr = (s_q.rd_ptr == AW'(DEPTH - 1)) ? '0 : s_q.rd_ptr + 1'b1;
        end
        if (do_push && !do_pop) begin
            s_d.count = s_q.count + 1'b1;
        end else if (do_pop && !do_push) begin
            s_d.count = s_q.count - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : trace_fifo

// ==== trace_fifo_if.sv ====
/*
 * Carrier between the encoder and its record FIFO.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps

interface trace_fifo_if;
    import trace_pkg::*;

    logic push_valid;
    logic push_ready;
    trace_rec_t push_data;
    logic pop_valid;
    logic pop_ready;
    trace_rec_t pop_data;
    fifo_lvl_t level;

    modport producer (
        output push_valid,
        input push_ready,
        output push_data,
        input pop_valid,
        output pop_ready,
        input pop_data,
        input level
    );

    modport buffer (
        input push_valid,
        output push_ready,
        input push_data,
        output pop_valid,
        input pop_ready,
        output pop_data,
        output level
    );

endinterface : trace_fifo_if

// ==== trace_pkg.sv ====
/*
 * Types shared by the trace encoder and its record FIFO.
 * Assumes trace_defs.svh supplies the widths.
 */
`include "trace_defs.svh"

package trace_pkg;

    typedef logic [`REC_W-1:0] trace_rec_t;
    typedef logic [7:0] stat_t;
    typedef logic [3:0] fifo_lvl_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK = 2'b01
    } wb_state_t;

endpackage : trace_pkg

// ==== trace_status_word_encoder.sv ====
/*
 * Trace status word encoder: builds one 48-bit trace record per processor bus
 * cycle, buffers it in an 8-deep FIFO toward the analyzer, and offers a
 * Wishbone register file for enable, status qualifier and status.
 * Assumes the emulated processor runs on clk_i, so its bus outputs are
 * synchronous and need no synchroniser; the analyzer drains with valid/ready.
 */
`timescale 1ns/1ps
`include "trace_defs.svh"

module trace_status_word_encoder
    import trace_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    // processor bus
    input wire logic addr_strobe_n_i,
    input wire logic [23:1] addr_i,
    input wire logic upper_byte_strobe_i,
    input wire logic [15:0] data_i,
    input wire logic [2:0] func_code_i,
    input wire logic read_i,
    input wire logic byte_access_i,
    input wire logic peripheral_cycle_flag_i,
    input wire logic guarded_access_n_i,
    input wire logic rom_access_n_i,
    input wire logic monitor_active_i,
    input wire logic dma_tag_i,
    output logic capture_ready_o,
    // analyzer side
    output logic trace_valid_o,
    input wire logic trace_ready_i,
    output logic [`REC_W-1:0] trace_rec_o,
    output logic qual_match_o,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);

    typedef struct packed {
        wb_state_t wb_state;
        logic [31:0] rd_data;
        logic enable;
        stat_t equ_val;
        stat_t equ_mask;
        stat_t qual_val;
        stat_t qual_mask;
        logic overflow;
        logic [15:0] match_cnt;
        logic strobe_seen;
        trace_rec_t pend_rec;
        logic push;
        trace_rec_t push_rec;
        logic match;
    } enc_state_t;

    enc_state_t s_q;
    enc_state_t s_d;

    trace_fifo_if fifo_bus ();

    trace_fifo #(
        .WIDTH(`REC_W),
        .DEPTH(`FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .f(fifo_bus)
    );

    logic [2:0] trace_fc;
    trace_rec_t live_rec;
    logic wb_req;
    logic wb_wr;
    logic cycle_end;
    logic pushed_match;

    // function code rewrite; a dma tag outranks monitor substitution
    always_comb begin
        trace_fc = func_code_i;
        if (dma_tag_i) begin
            trace_fc = `FC_DMA_TAG;
        end else if (monitor_active_i && func_code_i != `FC_INT_ACK) begin
            if (func_code_i[1]) begin
                trace_fc = `FC_MON_PROG;
            end else begin
                trace_fc = `FC_MON_DATA;
            end
        end
    end

    always_comb begin
        live_rec = '0;
        live_rec[`POS_STROBE] = upper_byte_strobe_i;
        live_rec[`POS_ADDR_HI:`POS_ADDR_LO] = addr_i;
        live_rec[`POS_BYTE] = byte_access_i;
        live_rec[`POS_READ] = read_i;
        live_rec[`POS_PERIPH] = peripheral_cycle_flag_i;
        live_rec[`POS_FC_HI:`POS_FC_LO] = trace_fc;
        live_rec[`POS_ROM_N] = rom_access_n_i;
        live_rec[`POS_GUARD_N] = guarded_access_n_i;
        live_rec[`POS_DATA_HI:`POS_DATA_LO] = data_i;
    end

    assign wb_req = wb_cyc_i && wb_stb_i && (s_q.wb_state == BUS_IDLE);
    assign wb_wr = wb_req && wb_we_i;
    // a cycle is recorded as the address strobe is released
    assign cycle_end = s_q.strobe_seen && addr_strobe_n_i;
    // status field compared against the latched qualifier, mask 1 means care
    assign pushed_match = (((s_q.push_rec[`POS_STAT_HI:`POS_STAT_LO] ^ s_q.qual_val)
        & s_q.qual_mask) == 8'h00);

    assign fifo_bus.push_valid = s_q.push;
    assign fifo_bus.push_data = s_q.push_rec;
    assign fifo_bus.pop_ready = trace_ready_i;
    assign trace_valid_o = fifo_bus.pop_valid;
    assign trace_rec_o = fifo_bus.pop_data;
    // the processor bus cannot be stalled mid-cycle; this lets the target hold off
    assign capture_ready_o = fifo_bus.push_ready;
    assign qual_match_o = s_q.match;
    assign wb_dat_o = s_q.rd_data;
    assign wb_ack_o = (s_q.wb_state == BUS_ACK);

    always_comb begin
        s_d = s_q;
        s_d.push = 1'b0;
        s_d.match = 1'b0;

        // capture: the record is sampled every cycle the strobe is low so
        // that the values at the end of the cycle are the ones kept
        if (!addr_strobe_n_i) begin
            s_d.strobe_seen = 1'b1;
            s_d.pend_rec = live_rec;
        end else begin
            s_d.strobe_seen = 1'b0;
        end
        if (cycle_end && s_q.enable) begin
            s_d.push_rec = s_q.pend_rec;
            s_d.push = 1'b1;
        end

        // a record offered to a full FIFO is lost and flagged
        if (s_q.push) begin
            s_d.match = pushed_match;
            if (pushed_match && fifo_bus.push_ready) begin
                s_d.match_cnt = s_q.match_cnt + 16'h0001;
            end
        end

        case (s_q.wb_state)
            BUS_IDLE: begin
                if (wb_req) begin
                    s_d.wb_state = BUS_ACK;
                    s_d.rd_data = 32'h0000_0000;
                    if (wb_adr_i == `OFS_CTRL) begin
                        s_d.rd_data[`CTRL_ENABLE_BIT] = s_q.enable;
                    end else if (wb_adr_i == `OFS_EQU_VAL) begin
                        s_d.rd_data[7:0] = s_q.equ_val;
                    end else if (wb_adr_i == `OFS_EQU_MASK) begin
                        s_d.rd_data[7:0] = s_q.equ_mask;
                    end else if (wb_adr_i == `OFS_QUAL) begin
                        s_d.rd_data[15:0] = {s_q.qual_mask, s_q.qual_val};
                    end else if (wb_adr_i == `OFS_STATUS) begin
                        s_d.rd_data[`STATUS_OVF_BIT] = s_q.overflow;
                        s_d.rd_data[`STATUS_LVL_HI:`STATUS_LVL_LO] = fifo_bus.level;
                    end else if (wb_adr_i == `OFS_MATCH_CNT) begin
                        s_d.rd_data[15:0] = s_q.match_cnt;
                    end
                end
            end
            BUS_ACK: begin
                s_d.wb_state = BUS_IDLE;
            end
            default: begin
                s_d.wb_state = BUS_IDLE;
            end
        endcase

        if (wb_wr && wb_sel_i[0]) begin
            if (wb_adr_i == `OFS_CTRL) begin
                s_d.enable = wb_dat_i[`CTRL_ENABLE_BIT];
                // the pattern is copied now; later equate writes leave it alone
                if (wb_dat_i[`CTRL_LOAD_BIT]) begin
                    s_d.qual_val = s_q.equ_val;
                    s_d.qual_mask = s_q.equ_mask;
                end
            end else if (wb_adr_i == `OFS_EQU_VAL) begin
                s_d.equ_val = wb_dat_i[7:0];
            end else if (wb_adr_i == `OFS_EQU_MASK) begin
                s_d.equ_mask = wb_dat_i[7:0];
            end else if (wb_adr_i == `OFS_STATUS) begin
                if (wb_dat_i[`STATUS_OVF_BIT]) begin
                    s_d.overflow = 1'b0;
                end
            end else if (wb_adr_i == `OFS_MATCH_CNT) begin
                s_d.match_cnt = `RST_COUNT;
            end
        end

        // set wins over a clear in the same cycle
        if (s_q.push && !fifo_bus.push_ready) begin
            s_d.overflow = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.wb_state <= BUS_IDLE;
            s_q.enable <= `RST_ENABLE;
            s_q.equ_val <= `RST_EQU;
            s_q.equ_mask <= `RST_MASK;
            s_q.qual_val <= `RST_EQU;
            s_q.qual_mask <= `RST_MASK;
            s_q.match_cnt <= `RST_COUNT;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : trace_status_word_encoder

// ==== trace_status_word_encoder_monitor.sv ====
/* Checker for the trace encoder: record fields against the captured bus cycle,
   record hold, bus answer timing. Assumes a record shows 3 edges after capture. */
`timescale 1ns/1ps
`include "trace_defs.svh"

module trace_status_word_encoder_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [23:1] addr_i,
    input wire logic upper_byte_strobe_i,
    input wire logic [15:0] data_i,
    input wire logic [2:0] func_code_i,
    input wire logic read_i,
    input wire logic byte_access_i,
    input wire logic peripheral_cycle_flag_i,
    input wire logic guarded_access_n_i,
    input wire logic rom_access_n_i,
    input wire logic monitor_active_i,
    input wire logic dma_tag_i,
    input wire logic capture_ready_o,
    input wire logic trace_valid_o,
    input wire logic trace_ready_i,
    input wire logic [`REC_W-1:0] trace_rec_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_DATA_MAP: assert property ($rose(trace_valid_o) |->
        trace_rec_o[47:32] == $past(data_i, 3)) else $error("data field wrong");
    AST_ADDR_MAP: assert property ($rose(trace_valid_o) |->
        trace_rec_o[23:0] == {$past(addr_i, 3), $past(upper_byte_strobe_i, 3)})
        else $error("address field wrong");
    AST_STAT_MAP: assert property ($rose(trace_valid_o) |->
        {trace_rec_o[31:30], trace_rec_o[26:24]} == {$past(guarded_access_n_i, 3),
        $past(rom_access_n_i, 3), $past(peripheral_cycle_flag_i, 3), $past(read_i, 3),
        $past(byte_access_i, 3)}) else $error("status flags wrong");
    AST_FC_FG: assert property ($rose(trace_valid_o) && !$past(monitor_active_i, 3) &&
        !$past(dma_tag_i, 3) |-> trace_rec_o[29:27] == $past(func_code_i, 3))
        else $error("foreground code altered");
    AST_FC_DMA: assert property ($rose(trace_valid_o) && $past(dma_tag_i, 3) |->
        trace_rec_o[29:27] == 3'h3) else $error("dma tag code wrong");
    AST_FC_MON: assert property ($rose(trace_valid_o) && $past(monitor_active_i, 3) &&
        !$past(dma_tag_i, 3) && $past(func_code_i, 3) != 3'h7 |-> trace_rec_o[29:27] ==
        ((($past(func_code_i, 3) & 3'h2) != 3'h0) ? 3'h0 : 3'h4)) else $error("monitor code");
    AST_REC_HOLD: assert property (trace_valid_o && !trace_ready_i |=>
        trace_valid_o && $stable(trace_rec_o)) else $error("record not held");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");

    COV_REC: cover property ($rose(trace_valid_o));
    COV_FULL: cover property (!capture_ready_o);
    COV_ACK: cover property (wb_ack_o);
endmodule : trace_status_word_encoder_monitor

bind trace_status_word_encoder trace_status_word_encoder_monitor u_mon (.*);
